// ===== mmsp_link.sv
// SCK-domain shift engine of the management SPI slave
`timescale 1ns/1ps
`default_nettype none
module mmsp_link (
  // Link clock and clears
  input wire logic sck_i,
  input wire logic frame_clr_i,
  input wire logic rst_i,
  // Serial data
  input wire logic mosi_i,
  output logic tx_bit_o,
  // Transaction fields
  input wire logic [7:0] rd_data_i,
  output logic [15:0] addr_o,
  output logic cmd_rd_o,
  output logic [7:0] wdata_o,
  output logic wr_tog_o
);
  import mmsp_pkg::*;

  logic [5:0] cnt_r;
  logic [6:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] byte_in;

  assign byte_in = {sh_r, mosi_i};
  assign tx_bit_o = tx_r[7];

  // Sample on rising edge, mode 0
  always_ff @(posedge sck_i or posedge frame_clr_i) begin
    if (frame_clr_i) begin
      cnt_r <= 6'h00;
      sh_r <= 7'h00;
      cmd_rd_o <= 1'b0;
    end else begin
      sh_r <= byte_in[6:0];
      if (cnt_r != CNT_SAT) begin
        cnt_r <= cnt_r + 6'h01;
      end
      if (cnt_r == CMD_LAST) begin
        cmd_rd_o <= byte_in[CMD_RD_BIT];
      end
    end
  end

  // Address and write word survive the frame clear: the write is decoded
  // in the local domain only after chip select has already gone high
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o <= 16'h0000;
      wdata_o <= 8'h00;
      wr_tog_o <= 1'b0;
    end else if (!frame_clr_i) begin
      if (cnt_r == ADDR_HI_LAST) begin
        addr_o[15:8] <= byte_in;
      end
      if (cnt_r == ADDR_LO_LAST) begin
        addr_o[7:0] <= byte_in;
      end
      if (cnt_r == DATA_LAST && !cmd_rd_o) begin
        wdata_o <= byte_in;
        wr_tog_o <= ~wr_tog_o;
      end
    end
  end

  // Shift out on falling edge; first data bit valid before next rise
  always_ff @(negedge sck_i or posedge frame_clr_i) begin
    if (frame_clr_i) begin
      tx_r <= 8'h00;
    end else if (cnt_r == CNT_SAT - 6'h08) begin
      tx_r <= rd_data_i;
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ===== mmsp_master_model.sv
// Behavioural mother-board master of the management link
`timescale 1ns/1ps
`default_nettype none
module mmsp_master_model (
  output logic sck_o, cs_n_o, steer_msb_o, steer_lsb_o, mosi_o,
  input wire logic miso_i
);
  // Clock stands low outside frames
  initial begin
    sck_o = 0; cs_n_o = 1; steer_msb_o = 0; steer_lsb_o = 0; mosi_o = 0;
  end
  task automatic frame(input logic [1:0] sp, input logic [31:0] w, output logic [7:0] rd);
    logic [31:0] sh;
    sh = '0;
    {steer_msb_o, steer_lsb_o} = sp;
    #24 cs_n_o = 0;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = w[i];
      #24 sck_o = 1;
      sh = {sh[30:0], miso_i};
      #24 sck_o = 0;
    end
    #24 cs_n_o = 1;
    mosi_o = 0;
    rd = sh[7:0];
  endtask
endmodule
`default_nettype wire

// ===== mmsp_pkg.sv
// Shared constants for the mezzanine management SPI port
package mmsp_pkg;
  // Steering codes on the two address pins
  localparam logic [1:0] SPACE_ID = 2'h0;
  localparam logic [1:0] SPACE_TEMP = 2'h1;
  localparam logic [1:0] SPACE_SPARE = 2'h2;
  localparam logic [1:0] SPACE_GPIO = 2'h3;
  // Frame layout in SCK rising edges
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] ADDR_HI_LAST = 6'h0F;
  localparam logic [5:0] ADDR_LO_LAST = 6'h17;
  localparam logic [5:0] DATA_LAST = 6'h1F;
  localparam logic [5:0] CNT_SAT = 6'h20;
  localparam int CMD_RD_BIT = 7;
  // Identification space locations
  localparam logic [15:0] ID_HI_ADDR = 16'h0000;
  localparam logic [15:0] ID_LO_ADDR = 16'h0001;
  localparam logic [15:0] INT_RELEASE_ADDR = 16'h0002;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  // Control/GPIO register offsets (low address byte)
  localparam logic [7:0] REG_GPIO_OUT = 8'h00;
  localparam logic [7:0] REG_GPIO_IN = 8'h01;
  localparam logic [7:0] REG_INT_STAT = 8'h02;
  localparam logic [7:0] REG_INT_MASK = 8'h03;
  // Reset values
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  // Link rate floor and local clock
  localparam int SCK_MIN_MHZ = 10;
  localparam int MCLK_MHZ = 10;
endpackage

// ===== mmsp_port.sv
// Daughter-board management port: steering, SPI slave, GPIO, reset and interrupt
`timescale 1ns/1ps
`default_nettype none
module mmsp_port #(
  parameter int GPIO_W = 8,
  parameter int IRQ_W = 8,
  parameter logic [15:0] BOARD_ID = 16'h0A5C // Arbitrary value
) (
  // Local clock and management reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // Management link from the mother board
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic STEER_ADDR_MSB_I,
  input wire logic STEER_ADDR_LSB_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  // Presence / interrupt pin
  output logic SLOT_PRESENT_N_O,
  output logic SLOT_PRESENT_N_OE_O,
  // Steered external buses
  output logic TEMP_CS_N_O,
  output logic SPARE_CS_N_O,
  output logic SUB_SCK_O,
  output logic SUB_MOSI_O,
  input wire logic TEMP_MISO_I,
  input wire logic SPARE_MISO_I,
  // Board control lines
  output logic [GPIO_W-1:0] GPIO_O,
  input wire logic [GPIO_W-1:0] GPIO_I,
  input wire logic [IRQ_W-1:0] IRQ_I
);
  import mmsp_pkg::*;

  logic [1:0] space;
  logic frame_clr;
  logic link_rst;
  logic [15:0] lk_addr;
  logic lk_cmd_rd;
  logic [7:0] lk_wdata;
  logic lk_wr_tog;
  logic tx_bit;
  logic [7:0] rd_data;
  logic [7:0] id_rd;
  logic [7:0] reg_rd;
  logic [2:0] tog_sync_r;
  logic wr_evt;
  logic [GPIO_W-1:0] gpio_s1_r, gpio_s2_r;
  logic [IRQ_W-1:0] irq_s1_r, irq_s2_r;
  logic [GPIO_W-1:0] gpio_out_r;
  logic [IRQ_W-1:0] int_stat_r, int_stat_nxt, int_mask_r;
  logic int_mode_r;
  logic int_pend;
  logic pin_oe_r;
  logic gpio_wr, stat_wr, mask_wr, rel_wr;

  // Steering decode; pins are stable for the whole frame
  assign space = {STEER_ADDR_MSB_I, STEER_ADDR_LSB_I};
  // Engine held clear during external-bus frames so they never post a write
  assign frame_clr = CS_N_I | ~RSTN_I | (space == SPACE_TEMP) | (space == SPACE_SPARE);
  assign link_rst = ~RSTN_I;

  mmsp_link u_link (
    .sck_i(SCK_I),
    .frame_clr_i(frame_clr),
    .rst_i(link_rst),
    .mosi_i(MOSI_I),
    .tx_bit_o(tx_bit),
    .rd_data_i(rd_data),
    .addr_o(lk_addr),
    .cmd_rd_o(lk_cmd_rd),
    .wdata_o(lk_wdata),
    .wr_tog_o(lk_wr_tog)
  );

  // Read data: ID constants and held registers. Register values only change
  // on local writes or slow inputs, so a rare torn read is the accepted cost
  // of answering within half an SCK period.
  assign id_rd = (lk_addr == ID_HI_ADDR) ? BOARD_ID[15:8] :
                 (lk_addr == ID_LO_ADDR) ? BOARD_ID[7:0] : UNMAPPED_READ;
  assign reg_rd = (lk_addr[7:0] == REG_GPIO_OUT) ? 8'(gpio_out_r) :
                  (lk_addr[7:0] == REG_GPIO_IN) ? 8'(gpio_s2_r) :
                  (lk_addr[7:0] == REG_INT_STAT) ? 8'(int_stat_r) :
                  (lk_addr[7:0] == REG_INT_MASK) ? 8'(int_mask_r) : UNMAPPED_READ;
  assign rd_data = (space == SPACE_ID) ? id_rd : reg_rd;

  // Steering to external buses; pass-through so their timing is unchanged
  assign TEMP_CS_N_O = CS_N_I | (space != SPACE_TEMP);
  assign SPARE_CS_N_O = CS_N_I | (space != SPACE_SPARE);
  assign SUB_SCK_O = SCK_I & ~CS_N_I;
  assign SUB_MOSI_O = MOSI_I & ~CS_N_I;
  assign MISO_O = (space == SPACE_TEMP) ? TEMP_MISO_I :
                  (space == SPACE_SPARE) ? SPARE_MISO_I : tx_bit;
  // Shared data line left alone outside our frame
  assign MISO_OE_O = ~CS_N_I & RSTN_I;

  // Write event crossing: toggle through two flops, edge on the third
  assign wr_evt = tog_sync_r[2] ^ tog_sync_r[1];
  assign gpio_wr = wr_evt && (space == SPACE_GPIO) && (lk_addr[7:0] == REG_GPIO_OUT);
  assign stat_wr = wr_evt && (space == SPACE_GPIO) && (lk_addr[7:0] == REG_INT_STAT);
  assign mask_wr = wr_evt && (space == SPACE_GPIO) && (lk_addr[7:0] == REG_INT_MASK);
  assign rel_wr = wr_evt && (space == SPACE_ID) && (lk_addr == INT_RELEASE_ADDR);

  // Write-one-to-clear; a new event in the clear cycle stays set
  assign int_stat_nxt = (stat_wr ? (int_stat_r & ~lk_wdata[IRQ_W-1:0]) : int_stat_r)
                        | irq_s2_r;
  assign int_pend = |(int_stat_r & int_mask_r);

  always_ff @(posedge MCLK_I) begin
    tog_sync_r <= {tog_sync_r[1:0], lk_wr_tog};
    gpio_s1_r <= GPIO_I;
    gpio_s2_r <= gpio_s1_r;
    irq_s1_r <= IRQ_I;
    irq_s2_r <= irq_s1_r;
  end

  // Management reset clears local control state and re-enables the presence drive
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      gpio_out_r <= GPIO_W'(GPIO_OUT_RST);
      int_mask_r <= IRQ_W'(INT_MASK_RST);
      int_stat_r <= '0;
      int_mode_r <= 1'b0;
      pin_oe_r <= 1'b1;
    end else begin
      if (gpio_wr) begin
        gpio_out_r <= lk_wdata[GPIO_W-1:0];
      end
      if (mask_wr) begin
        int_mask_r <= lk_wdata[IRQ_W-1:0];
      end
      int_stat_r <= int_stat_nxt;
      if (rel_wr) begin
        int_mode_r <= 1'b1;
      end
      // Presence drives low; interrupt mode drives low only when pending
      pin_oe_r <= int_mode_r ? int_pend : 1'b1;
    end
  end

  assign GPIO_O = gpio_out_r;
  assign SLOT_PRESENT_N_O = 1'b0;
  assign SLOT_PRESENT_N_OE_O = pin_oe_r;
endmodule
`default_nettype wire

// ===== mmsp_port_properties.sv
// Pin-level checks of the management SPI port
`timescale 1ns/1ps
`default_nettype none
module mmsp_port_props
  import mmsp_pkg::*;
#(parameter int GPIO_W = 8) (
  // Clock, reset and link
  input wire logic MCLK_I, RSTN_I, SCK_I, CS_N_I, STEER_ADDR_MSB_I, STEER_ADDR_LSB_I,
  input wire logic MISO_O, MISO_OE_O, TEMP_MISO_I,
  // Presence, steered and GPIO pins
  input wire logic SLOT_PRESENT_N_O, SLOT_PRESENT_N_OE_O, TEMP_CS_N_O, SPARE_CS_N_O,
  input wire logic SUB_SCK_O,
  input wire logic [GPIO_W-1:0] GPIO_O
);
  default clocking @(posedge MCLK_I); endclocking
  wire logic sel = !CS_N_I;
  wire logic [1:0] sp = {STEER_ADDR_MSB_I, STEER_ADDR_LSB_I};
  miso_release_a: assert property (MISO_OE_O == (sel && RSTN_I))
    else $error("miso enable wrong");
  temp_sel_a: assert property (TEMP_CS_N_O == !(sel && sp == SPACE_TEMP))
    else $error("temp select wrong");
  spare_sel_a: assert property (SPARE_CS_N_O == !(sel && sp == SPACE_SPARE))
    else $error("spare select wrong");
  temp_data_a: assert property (sel && sp == SPACE_TEMP |-> MISO_O == TEMP_MISO_I)
    else $error("temp data not passed");
  sub_clock_a: assert property (SUB_SCK_O == (SCK_I && sel))
    else $error("sub clock wrong");
  present_low_a: assert property (SLOT_PRESENT_N_OE_O |-> !SLOT_PRESENT_N_O)
    else $error("pin not driven low");
  present_rst_a: assert property (!RSTN_I |=> SLOT_PRESENT_N_OE_O)
    else $error("presence not restored");
  gpio_rst_a: assert property (!RSTN_I |=> GPIO_O == GPIO_OUT_RST)
    else $error("gpio not cleared");
  gpio_quiet_a: assert property (disable iff (!RSTN_I) CS_N_I [*6] |=> $stable(GPIO_O))
    else $error("gpio moved while idle");
  cover property (sel && sp == SPACE_GPIO);
  cover property (sel && sp == SPACE_TEMP);
  cover property (disable iff (!RSTN_I) $fell(SLOT_PRESENT_N_OE_O));
endmodule
bind mmsp_port mmsp_port_props #(.GPIO_W(GPIO_W)) u_props (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
  .SCK_I(SCK_I), .CS_N_I(CS_N_I), .STEER_ADDR_MSB_I(STEER_ADDR_MSB_I),
  .STEER_ADDR_LSB_I(STEER_ADDR_LSB_I), .MISO_O(MISO_O), .MISO_OE_O(MISO_OE_O),
  .TEMP_MISO_I(TEMP_MISO_I), .SLOT_PRESENT_N_O(SLOT_PRESENT_N_O),
  .SLOT_PRESENT_N_OE_O(SLOT_PRESENT_N_OE_O), .TEMP_CS_N_O(TEMP_CS_N_O),
  .SPARE_CS_N_O(SPARE_CS_N_O), .SUB_SCK_O(SUB_SCK_O), .GPIO_O(GPIO_O));
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the management SPI port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mmsp_pkg::*;
  localparam logic [15:0] ID = 16'h3C96; // Arbitrary value
  logic mclk, rstn, sck, cs_n, msb, lsb, mosi, miso, oe, pres, pres_oe, tcs, scs, ssck, smosi;
  logic [7:0] gpo, gpi, irq, rd;
  int n_fail = 0, num_checks = 0, cyc = 0;
  wire logic miso_w = oe ? miso : 1'b0;
  // Interrupt line idles high via the pull-up
  wire logic int_n = pres_oe ? pres : 1'b1;
  mmsp_port #(.BOARD_ID(ID)) uut (.MCLK_I(mclk), .RSTN_I(rstn), .SCK_I(sck), .CS_N_I(cs_n),
    .STEER_ADDR_MSB_I(msb), .STEER_ADDR_LSB_I(lsb), .MOSI_I(mosi), .MISO_O(miso),
    .MISO_OE_O(oe), .SLOT_PRESENT_N_O(pres), .SLOT_PRESENT_N_OE_O(pres_oe),
    .TEMP_CS_N_O(tcs), .SPARE_CS_N_O(scs), .SUB_SCK_O(ssck), .SUB_MOSI_O(smosi),
    .TEMP_MISO_I(~smosi), .SPARE_MISO_I(smosi), .GPIO_O(gpo), .GPIO_I(gpi), .IRQ_I(irq));
  mmsp_master_model m (.sck_o(sck), .cs_n_o(cs_n), .steer_msb_o(msb), .steer_lsb_o(lsb),
    .mosi_o(mosi), .miso_i(miso_w));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [1:0] sp, input int r, input logic [7:0] a, input logic [7:0] d);
    m.frame(sp, {r[0], 7'h00, 8'h00, a, d}, rd);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_id;
    logic [7:0] hi;
    xf(SPACE_ID, 1, ID_HI_ADDR[7:0], 8'h00);
    chk(rd, ID[15:8]);
    hi = rd;
    xf(SPACE_ID, 1, ID_LO_ADDR[7:0], 8'h00);
    chk(rd, ID[7:0]);
    chk({7'h00, &{hi, rd}}, 8'h00);
    xf(SPACE_ID, 1, 8'h40, 8'h00);
    chk(rd, UNMAPPED_READ);
  endtask
  task automatic t_gpio;
    xf(SPACE_GPIO, 0, REG_GPIO_OUT, 8'hA5);
    ticks(6);
    chk(gpo, 8'hA5);
    xf(SPACE_GPIO, 1, REG_GPIO_OUT, 8'h00);
    chk(rd, 8'hA5);
    @(posedge mclk) gpi <= 8'h3C;
    ticks(3);
    xf(SPACE_GPIO, 0, REG_GPIO_IN, 8'h00);
    xf(SPACE_GPIO, 1, REG_GPIO_IN, 8'h00);
    chk(rd, 8'h3C);
    chk(gpo, 8'hA5);
    xf(SPACE_GPIO, 1, 8'h10, 8'h00);
    chk(rd, UNMAPPED_READ);
  endtask
  task automatic t_steer;
    // Fake sensor inverts, spare bus echoes
    for (int k = 0; k < 2; k++) begin
      xf(k ? SPACE_SPARE : SPACE_TEMP, 0, 8'h34, 8'h5A);
      chk(rd, k ? 8'h5A : 8'hA5);
    end
  endtask
  task automatic t_irq;
    xf(SPACE_ID, 0, INT_RELEASE_ADDR[7:0], 8'h00);
    ticks(6);
    chk({7'h00, int_n}, 8'h01);
    xf(SPACE_GPIO, 0, REG_INT_MASK, 8'h01);
    @(posedge mclk) irq <= 8'h01;
    ticks(8);
    chk({7'h00, int_n}, 8'h00);
    xf(SPACE_GPIO, 1, REG_INT_STAT, 8'h00);
    chk(rd, 8'h01);
    @(posedge mclk) irq <= 8'h00;
    ticks(3);
    xf(SPACE_GPIO, 0, REG_INT_STAT, 8'h01);
    ticks(6);
    chk({7'h00, int_n}, 8'h01);
    @(posedge mclk) rstn <= 0;
    ticks(3);
    chk({7'h00, pres_oe}, 8'h01);
    chk(gpo, GPIO_OUT_RST);
    @(posedge mclk) rstn <= 1;
    ticks(2);
  endtask
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR %0t: timeout", $time);
      wrap_up;
    end
  end
  initial begin
    rstn = 0;
    gpi = 8'h00;
    irq = 8'h00;
    ticks(10);
    rstn <= 1;
    ticks(2);
    chk({7'h00, pres_oe}, 8'h01);
    chk({7'h00, oe}, 8'h00);
    chk(gpo, GPIO_OUT_RST);
    t_id;
    t_gpio;
    t_steer;
    t_irq;
    wrap_up;
  end
endmodule
`default_nettype wire
